// [bench/acc_cal_regs_sva.sv]
// Port-level checker for the calibration register bank.
// Assumes hready is tied to hreadyout and only word transfers occur.
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.vh"
module acc_cal_regs_sva (
  input wire logic clk, // Clock
  input wire logic rst_b, // Sync reset, active low
  input wire logic hsel, // Select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic hresp, // Response
  input wire logic [31:0] hrdata, // Read data
  input wire logic calibrationTriggerPin, // Trigger pin
  input wire logic alarmFlag, // Alarm input
  input wire logic calibrationStatusPin, // Status pin
  input wire logic offlineAsleep, // Sleep output
  input wire logic irq // Interrupt
);
  logic take;
  logic rdReq;
  logic wrReq;
  logic trig;
  logic wrPend;
  logic softReg;
  logic [7:0] wrIdx;
  logic [2:0] pinReg;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Request decode and the trigger the bank should be using
  assign take = hsel && hready && htrans[1] && hsize == 3'h2;
  assign rdReq = take && !hwrite;
  assign wrReq = take && hwrite;
  assign trig = pinReg[0] ? calibrationTriggerPin : softReg;
  // Shadow copies, updated at the same edge as the bank's own registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wrPend <= 1'b0;
      wrIdx <= 8'h00;
      pinReg <= 3'h0;
      softReg <= 1'b1;
    end else if (hready) begin
      wrPend <= wrReq;
      wrIdx <= haddr[9:2];
      if (wrPend && wrIdx == `ACC_IDX_PIN_SETUP) pinReg <= hwdata[2:0];
      if (wrPend && wrIdx == `ACC_IDX_SOFT_TRIG) softReg <= hwdata[0];
    end
  end
  sequence readWait;
    !hreadyout ##1 hreadyout;
  endsequence
  reset_quiet_a: assert property ($rose(rst_b) |-> hreadyout && !irq && !offlineAsleep && !calibrationStatusPin)
    else $error("outputs not quiet after reset");
  hresp_okay_a: assert property (!hresp)
    else $error("error response seen");
  hrdata_upper_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  write_nowait_a: assert property (wrReq |=> hreadyout)
    else $error("write inserted a wait");
  read_wait_a: assert property (rdReq |=> readWait)
    else $error("read wait state wrong");
  wait_cause_a: assert property (!hreadyout |-> $past(rdReq))
    else $error("wait without a read");
  pin_low_a: assert property (pinReg[2:1] == 2'h3 && $past(pinReg[2:1]) == 2'h3 |-> !calibrationStatusPin)
    else $error("status pin not held low");
  pin_alarm_a: assert property (pinReg[2:1] == 2'h2 && $past(pinReg[2:1]) == 2'h2 |-> calibrationStatusPin == $past(alarmFlag))
    else $error("status pin not following alarm");
  asleep_trig_a: assert property (offlineAsleep |-> $past(trig))
    else $error("asleep while trigger low");
endmodule // acc_cal_regs_sva
bind acc_cal_regs acc_cal_regs_sva u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .calibrationTriggerPin(calibrationTriggerPin), .alarmFlag(alarmFlag),
  .calibrationStatusPin(calibrationStatusPin), .offlineAsleep(offlineAsleep), .irq(irq));
`default_nettype wire

// [bench/acc_far_end.sv]
// External logic beside the bank: drives trigger and alarm, watches the status pin.
// Assumes the bench sets the wanted levels; LAG adds extra delay cycles (0 to 3).
`timescale 1ns/1ns
`default_nettype none
module acc_far_end #(
  parameter int LAG = 0
) (
  input wire logic clk, // Clock
  input wire logic trigCmd, // Wanted trigger level
  input wire logic alarmCmd, // Wanted alarm level
  input wire logic calibrationStatusPin, // Watched status pin
  output logic calibrationTriggerPin, // Trigger to the bank
  output logic alarmFlag, // Alarm to the bank
  output logic [7:0] pinRises // Rising edges seen on the status pin
);
  logic [3:0] trigLine;
  logic [3:0] alarmLine;
  logic lastPin;
  // Delay line lets the far side answer promptly or slowly
  always @(posedge clk) begin
    trigLine <= {trigLine[2:0], trigCmd};
    alarmLine <= {alarmLine[2:0], alarmCmd};
    lastPin <= calibrationStatusPin;
    if (calibrationStatusPin && !lastPin) begin
      pinRises <= pinRises + 8'h01;
    end
  end
  assign calibrationTriggerPin = trigLine[LAG];
  assign alarmFlag = alarmLine[LAG];
  // Lines start idle so no false edge is seen before the bank leaves reset
  initial begin
    trigLine = 4'h0;
    alarmLine = 4'h0;
    lastPin = 1'b1;
    pinRises = 8'h00;
  end
endmodule // acc_far_end
`default_nettype wire

// [bench/tb_adc_calibration_control_regs.sv]
// Self-checking bench for the calibration register bank.
// Assumes the bank answers reads after one wait state and writes at once.
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.vh"
module tb_adc_calibration_control_regs;
  typedef struct packed {logic [7:0] idx; logic wr; logic [7:0] wd; logic [7:0] exp;} acc_row_t;
  logic clk, rst_b, hsel, hwrite, hreadyout, hresp, trigCmd, alarmCmd;
  logic trigPin, alarm, statusPin, asleep, irq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] rd, pinRises;
  int badCount, testsRun;
  acc_row_t rows [12];
  logic pinExp [4];
  // Short phases keep the run brief
  acc_cal_regs #(.FG_BASE_CYCLES(4), .BG_BASE_CYCLES(2)) u_dut (.clk(clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .calibrationTriggerPin(trigPin), .alarmFlag(alarm),
    .calibrationStatusPin(statusPin), .offlineAsleep(asleep), .irq(irq));
  acc_far_end #(.LAG(0)) u_far (.clk(clk), .trigCmd(trigCmd), .alarmCmd(alarmCmd),
    .calibrationStatusPin(statusPin), .calibrationTriggerPin(trigPin), .alarmFlag(alarm),
    .pinRises(pinRises));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    testsRun++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", what, exp, got);
      badCount++;
    end
  endtask
  task automatic giveVerdict();
    $display("Checks %0d mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Bounded wait for hready high at a rising edge
  task automatic waitReady();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (n >= 20) begin
      badCount++;
      giveVerdict();
    end
  endtask
  // One single word transfer; read data lands in rd
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    waitReady();
    rd = hrdata[7:0];
  endtask
  task automatic pollStatus(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      bus(`ACC_IDX_STATUS, 1'b0, 8'h00);
      n++;
    end while (rd !== exp && n < 40);
    check("status", exp, rd);
  endtask
  task automatic pinCheck(input string what, input logic exp);
    repeat (2) @(posedge clk);
    #1;
    check(what, {7'h0, exp}, {7'h0, statusPin});
  endtask
  initial begin
    rst_b = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    trigCmd = 1'b0;
    alarmCmd = 1'b0;
    badCount = 0;
    testsRun = 0;
    // Reserved bits written as zero, except 8'h5a written to the hole at 8'h69
    rows = '{'{8'h68, 0, 8'h00, 8'h61}, '{8'h6b, 0, 8'h00, 8'h00}, '{8'h6c, 0, 8'h00, 8'h01},
      '{8'h6e, 0, 8'h00, 8'h88}, '{8'h72, 0, 8'h00, 8'h00}, '{8'h68, 1, 8'h72, 8'h72},
      '{8'h68, 1, 8'h35, 8'h35}, '{8'h6b, 1, 8'h07, 8'h07}, '{8'h6c, 1, 8'h00, 8'h00},
      '{8'h6e, 1, 8'h8b, 8'h8b}, '{8'h72, 1, 8'h07, 8'h07}, '{8'h69, 1, 8'h5a, 8'h00}};
    pinExp = '{1'b1, 1'b1, 1'b1, 1'b0};
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) bus(rows[i].idx, 1'b1, rows[i].wd);
      bus(rows[i].idx, 1'b0, 8'h00);
      check("register", rows[i].exp, rd);
    end
    $display("register table done");
    pollStatus(8'h13);
    bus(`ACC_IDX_STATUS, 1'b1, 8'h00);
    pollStatus(8'h13);
    $display("status done");
    alarmCmd <= 1'b1;
    foreach (pinExp[i]) begin
      bus(`ACC_IDX_PIN_SETUP, 1'b1, {5'h0, i[1:0], 1'b0});
      pinCheck("status pin", pinExp[i]);
    end
    alarmCmd <= 1'b0;
    bus(`ACC_IDX_PIN_SETUP, 1'b1, 8'h04);
    pinCheck("alarm pin", 1'b0);
    check("pin rises", 8'h01, {7'h0, pinRises != 8'h00});
    $display("pin source done");
    // Interrupt: clear, raise while masked, unmask, then read-clear
    bus(`ACC_IDX_IRQ_MASK, 1'b1, 8'h00);
    bus(`ACC_IDX_IRQ_STATUS, 1'b0, 8'h00);
    alarmCmd <= 1'b1;
    pinCheck("irq masked", 1'b1);
    check("irq masked", 8'h00, {7'h0, irq});
    bus(`ACC_IDX_IRQ_MASK, 1'b1, 8'h04);
    pinCheck("irq raised", 1'b1);
    check("irq raised", 8'h01, {7'h0, irq});
    bus(`ACC_IDX_IRQ_STATUS, 1'b0, 8'h00);
    check("irq status", 8'h04, rd);
    pinCheck("irq cleared", 1'b1);
    check("irq cleared", 8'h00, {7'h0, irq});
    $display("interrupt done");
    // Background run: software trigger first, then the pin
    bus(`ACC_IDX_PIN_SETUP, 1'b1, 8'h00);
    bus(`ACC_IDX_SOFT_TRIG, 1'b1, 8'h01);
    bus(`ACC_IDX_CONTROL, 1'b1, 8'h00);
    pollStatus(8'h00);
    bus(`ACC_IDX_CONTROL, 1'b1, 8'h03);
    repeat (40) @(posedge clk);
    pollStatus(8'h09);
    check("asleep", 8'h01, {7'h0, asleep});
    bus(`ACC_IDX_SOFT_TRIG, 1'b1, 8'h00);
    pollStatus(8'h0f);
    check("awake", 8'h00, {7'h0, asleep});
    bus(`ACC_IDX_PIN_SETUP, 1'b1, 8'h01);
    trigCmd <= 1'b1;
    pollStatus(8'h09);
    trigCmd <= 1'b0;
    pollStatus(8'h0f);
    $display("background done");
    // Mid-run reset: settings return to defaults and the sequencer restarts
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    bus(`ACC_IDX_AVERAGING, 1'b0, 8'h00);
    check("reset averaging", `ACC_RST_AVERAGING, rd);
    bus(`ACC_IDX_SOFT_TRIG, 1'b0, 8'h00);
    check("reset trigger", `ACC_RST_SOFT_TRIG, rd);
    pollStatus(8'h13);
    $display("reset done");
    giveVerdict();
  end
endmodule // tb_adc_calibration_control_regs
`default_nettype wire

// [rtl/acc_cal_regs.v]
// Calibration control register bank with a small calibration sequencer.
// Assumes one AHB-Lite master, a single clock, trigger and alarm inputs
// already synchronous to clk.
`timescale 1ns/1ns
`default_nettype none
`include "acc_consts.vh"

module acc_cal_regs #(
  parameter FG_BASE_CYCLES = `ACC_FG_BASE_CYCLES,
  parameter BG_BASE_CYCLES = `ACC_BG_BASE_CYCLES
) (
  input wire clk, // 100 MHz clock
  input wire rst_b, // Synchronous reset, active low
  input wire hsel, // Slave select
  input wire [31:0] haddr, // Byte address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready
  output reg hreadyout, // Slave ready
  output reg hresp, // Always OKAY
  output reg [31:0] hrdata, // Read data
  input wire calibrationTriggerPin, // External trigger input
  input wire alarmFlag, // Alarm flag from the device
  output reg calibrationStatusPin, // Status output pin
  output reg offlineAsleep, // Offline converter held asleep
  output reg irq // Level interrupt
);

  // Sequencer states double as the status code
  localparam [2:0] ST_HOLD = 3'h0;
  localparam [2:0] ST_FG = 3'h1;
  localparam [2:0] ST_BG = 3'h2;
  localparam [2:0] ST_STOPPED = 3'h3;
  localparam [2:0] ST_DONE = 3'h4;
  localparam [23:0] FG_BASE = FG_BASE_CYCLES[23:0];
  localparam [23:0] BG_BASE = BG_BASE_CYCLES[23:0];

  // Phase length, doubled per averaging step, minus one for the down counter
  function [23:0] phaseLen;
    input [23:0] base;
    input [2:0] code;
    begin
      phaseLen = (base << code) - 24'h000001;
    end
  endfunction

  // Register fields
  reg [2:0] offsetAveragingSelect;
  reg [2:0] linearityAveragingSelect;
  reg [1:0] statusPinSelect;
  reg triggerSourceSelect;
  reg softwareTriggerBit;
  reg [2:0] sleepDelaySel;
  reg [1:0] wakeDelaySel;
  reg triggeredSleepMode;
  reg lowPowerEnable;
  reg calEnable;
  reg backgroundCalibrationEnable;
  reg foregroundRun;
  reg [2:0] irqStatus;
  reg [2:0] irqMask;

  // Sequencer state
  reg [2:0] state;
  reg [23:0] cnt;
  reg foregroundCompleteFlag;
  reg calStopped;
  reg fgPrev;
  reg stopPrev;
  reg alarmPrev;

  // Bus data-phase bookkeeping
  reg wrPend;
  reg rdPend;
  reg [7:0] accIdx;

  wire addrOk;
  wire accept;
  wire trig;
  wire [23:0] fgLen;
  wire [23:0] bgLen;
  wire [2:0] events;
  wire rdClear;
  reg [7:0] readMux;
  reg [2:0] next_irqStatus;

  // Only whole aligned words in the low 1 KiB decode
  assign addrOk = (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0) &&
                  (hsize == 3'h2);
  assign accept = hsel && hready && htrans[1];

  // Trigger source selection
  assign trig = triggerSourceSelect ? calibrationTriggerPin
                                    : softwareTriggerBit;

  assign fgLen = phaseLen(FG_BASE, linearityAveragingSelect);
  assign bgLen = phaseLen(BG_BASE, offsetAveragingSelect);

  // Address phase capture; reads take one wait state so that a
  // preceding write has landed before the data is sampled
  always @(posedge clk) begin
    if (!rst_b) begin
      wrPend <= 1'b0;
      rdPend <= 1'b0;
      accIdx <= 8'h00;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (rdPend) begin
        rdPend <= 1'b0;
        hreadyout <= 1'b1;
      end
      wrPend <= accept && hwrite && addrOk;
      if (accept) begin
        accIdx <= addrOk ? haddr[9:2] : 8'hff;
        if (!hwrite) begin
          rdPend <= 1'b1;
          hreadyout <= 1'b0;
        end
      end
    end
  end

  // Read mux; reserved bits read zero, unmapped reads zero
  always @* begin
    readMux = 8'h00;
    case (accIdx)
      `ACC_IDX_AVERAGING: begin
        readMux[`ACC_OFS_AVG_HI:`ACC_OFS_AVG_LO] = offsetAveragingSelect;
        readMux[`ACC_LIN_AVG_HI:`ACC_LIN_AVG_LO] = linearityAveragingSelect;
      end
      `ACC_IDX_STATUS: begin
        readMux[`ACC_STAT_CODE_HI:`ACC_STAT_CODE_LO] = state;
        readMux[`ACC_STAT_STOPPED] = calStopped;
        readMux[`ACC_STAT_FG_COMPLETE] = foregroundCompleteFlag;
      end
      `ACC_IDX_PIN_SETUP: begin
        readMux[`ACC_PIN_SEL_HI:`ACC_PIN_SEL_LO] = statusPinSelect;
        readMux[`ACC_PIN_TRIG_SRC] = triggerSourceSelect;
      end
      `ACC_IDX_SOFT_TRIG: begin
        readMux[0] = softwareTriggerBit;
      end
      `ACC_IDX_LOW_POWER: begin
        readMux[`ACC_LP_SLEEP_HI:`ACC_LP_SLEEP_LO] = sleepDelaySel;
        readMux[`ACC_LP_WAKE_HI:`ACC_LP_WAKE_LO] = wakeDelaySel;
        readMux[`ACC_LP_TRIGGERED] = triggeredSleepMode;
        readMux[`ACC_LP_ENABLE] = lowPowerEnable;
      end
      `ACC_IDX_CONTROL: begin
        readMux[`ACC_CTL_ENABLE] = calEnable;
        readMux[`ACC_CTL_BACKGROUND] = backgroundCalibrationEnable;
        readMux[`ACC_CTL_FOREGROUND] = foregroundRun;
      end
      `ACC_IDX_IRQ_STATUS: begin
        readMux[2:0] = irqStatus;
      end
      `ACC_IDX_IRQ_MASK: begin
        readMux[2:0] = irqMask;
      end
      default: begin
        readMux = 8'h00;
      end
    endcase
  end

  // Read data sampled in the wait cycle
  always @(posedge clk) begin
    if (!rst_b) begin
      hrdata <= 32'h00000000;
    end else if (rdPend) begin
      hrdata <= {24'h000000, readMux};
    end
  end

  // Register writes in the data phase; reserved bits are not stored,
  // so software that breaks the reserved-bit convention cannot upset us
  always @(posedge clk) begin
    if (!rst_b) begin
      offsetAveragingSelect <= 3'h6;
      linearityAveragingSelect <= 3'h1;
      statusPinSelect <= 2'h0;
      triggerSourceSelect <= 1'b0;
      softwareTriggerBit <= 1'b1;
      sleepDelaySel <= 3'h4;
      wakeDelaySel <= 2'h1;
      triggeredSleepMode <= 1'b0;
      lowPowerEnable <= 1'b0;
      calEnable <= 1'b1;
      backgroundCalibrationEnable <= 1'b0;
      foregroundRun <= 1'b1;
      irqMask <= 3'h0;
    end else if (wrPend) begin
      case (accIdx)
        `ACC_IDX_AVERAGING: begin
          offsetAveragingSelect <= hwdata[`ACC_OFS_AVG_HI:`ACC_OFS_AVG_LO];
          linearityAveragingSelect <= hwdata[`ACC_LIN_AVG_HI:`ACC_LIN_AVG_LO];
        end
        `ACC_IDX_PIN_SETUP: begin
          statusPinSelect <= hwdata[`ACC_PIN_SEL_HI:`ACC_PIN_SEL_LO];
          triggerSourceSelect <= hwdata[`ACC_PIN_TRIG_SRC];
        end
        `ACC_IDX_SOFT_TRIG: begin
          softwareTriggerBit <= hwdata[0];
        end
        `ACC_IDX_LOW_POWER: begin
          sleepDelaySel <= hwdata[`ACC_LP_SLEEP_HI:`ACC_LP_SLEEP_LO];
          wakeDelaySel <= hwdata[`ACC_LP_WAKE_HI:`ACC_LP_WAKE_LO];
          triggeredSleepMode <= hwdata[`ACC_LP_TRIGGERED];
          lowPowerEnable <= hwdata[`ACC_LP_ENABLE];
        end
        `ACC_IDX_CONTROL: begin
          calEnable <= hwdata[`ACC_CTL_ENABLE];
          backgroundCalibrationEnable <= hwdata[`ACC_CTL_BACKGROUND];
          foregroundRun <= hwdata[`ACC_CTL_FOREGROUND];
        end
        `ACC_IDX_IRQ_MASK: begin
          irqMask <= hwdata[2:0];
        end
        default: begin
          // Status registers and holes ignore writes
          offsetAveragingSelect <= offsetAveragingSelect;
        end
      endcase
    end
  end

  // Sequencer; a low enable holds everything in reset so settings
  // can be changed safely
  always @(posedge clk) begin
    if (!rst_b || !calEnable) begin
      state <= ST_HOLD;
      cnt <= 24'h000000;
      foregroundCompleteFlag <= 1'b0;
      calStopped <= 1'b0;
    end else begin
      case (state)
        ST_HOLD: begin
          if (foregroundRun) begin
            state <= ST_FG;
            cnt <= fgLen;
          end else begin
            foregroundCompleteFlag <= 1'b1;
            if (backgroundCalibrationEnable) begin
              state <= ST_BG;
              cnt <= bgLen;
            end else begin
              state <= ST_DONE;
              calStopped <= 1'b1;
            end
          end
        end
        ST_FG: begin
          if (cnt == 24'h000000) begin
            foregroundCompleteFlag <= 1'b1;
            if (backgroundCalibrationEnable) begin
              state <= ST_BG;
              cnt <= bgLen;
            end else begin
              state <= ST_DONE;
              calStopped <= 1'b1;
            end
          end else begin
            cnt <= cnt - 24'h000001;
          end
        end
        ST_BG: begin
          // A low trigger asks for a halt, honoured only at a phase end
          if (cnt == 24'h000000) begin
            if (!trig) begin
              state <= ST_STOPPED;
              calStopped <= 1'b1;
            end else begin
              cnt <= bgLen;
            end
          end else begin
            cnt <= cnt - 24'h000001;
          end
        end
        ST_STOPPED: begin
          if (trig) begin
            state <= ST_BG;
            cnt <= bgLen;
            calStopped <= 1'b0;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  // Sticky interrupt bits on rising events; set beats read-clear
  assign events = {alarmFlag & ~alarmPrev, calStopped & ~stopPrev,
                   foregroundCompleteFlag & ~fgPrev};
  assign rdClear = rdPend && (accIdx == `ACC_IDX_IRQ_STATUS);

  always @* begin
    next_irqStatus = irqStatus;
    if (rdClear) begin
      next_irqStatus = 3'h0;
    end
    next_irqStatus = next_irqStatus | events;
  end

  always @(posedge clk) begin
    if (!rst_b) begin
      irqStatus <= 3'h0;
      fgPrev <= 1'b0;
      stopPrev <= 1'b0;
      alarmPrev <= 1'b0;
      irq <= 1'b0;
    end else begin
      irqStatus <= next_irqStatus;
      fgPrev <= foregroundCompleteFlag;
      stopPrev <= calStopped;
      alarmPrev <= alarmFlag;
      irq <= |(next_irqStatus & irqMask);
    end
  end

  // Pin outputs, registered to keep them glitch free
  always @(posedge clk) begin
    if (!rst_b) begin
      calibrationStatusPin <= 1'b0;
      offlineAsleep <= 1'b0;
    end else begin
      case (statusPinSelect)
        `ACC_PIN_SRC_FG: calibrationStatusPin <= foregroundCompleteFlag;
        `ACC_PIN_SRC_STOPPED: calibrationStatusPin <= calStopped;
        `ACC_PIN_SRC_ALARM: calibrationStatusPin <= alarmFlag;
        default: calibrationStatusPin <= 1'b0;
      endcase
      // Awake while the trigger is low, asleep while high
      offlineAsleep <= backgroundCalibrationEnable && lowPowerEnable &&
                       triggeredSleepMode && trig &&
                       ((state == ST_BG) || (state == ST_STOPPED));
    end
  end

endmodule // acc_cal_regs
`default_nettype wire

// [rtl/acc_consts.vh]
// Constants for the calibration control register bank.
// Assumes inclusion by bare name from the design files in rtl/.
`ifndef ACC_CONSTS_VH
`define ACC_CONSTS_VH

// Register indices; byte address is four times the index
`define ACC_IDX_AVERAGING 8'h68
`define ACC_IDX_STATUS 8'h6a
`define ACC_IDX_PIN_SETUP 8'h6b
`define ACC_IDX_SOFT_TRIG 8'h6c
`define ACC_IDX_LOW_POWER 8'h6e
`define ACC_IDX_CONTROL 8'h70
`define ACC_IDX_IRQ_STATUS 8'h71
`define ACC_IDX_IRQ_MASK 8'h72

// Reset values
`define ACC_RST_AVERAGING 8'h61
`define ACC_RST_PIN_SETUP 8'h00
`define ACC_RST_SOFT_TRIG 8'h01
`define ACC_RST_LOW_POWER 8'h88
`define ACC_RST_CONTROL 8'h05
`define ACC_RST_IRQ_MASK 8'h00

// Averaging register fields
`define ACC_OFS_AVG_HI 6
`define ACC_OFS_AVG_LO 4
`define ACC_LIN_AVG_HI 2
`define ACC_LIN_AVG_LO 0

// Status register fields
`define ACC_STAT_CODE_HI 4
`define ACC_STAT_CODE_LO 2
`define ACC_STAT_STOPPED 1
`define ACC_STAT_FG_COMPLETE 0

// Pin setup fields
`define ACC_PIN_SEL_HI 2
`define ACC_PIN_SEL_LO 1
`define ACC_PIN_TRIG_SRC 0

// Low-power fields
`define ACC_LP_SLEEP_HI 7
`define ACC_LP_SLEEP_LO 5
`define ACC_LP_WAKE_HI 4
`define ACC_LP_WAKE_LO 3
`define ACC_LP_TRIGGERED 1
`define ACC_LP_ENABLE 0

// Control fields
`define ACC_CTL_ENABLE 0
`define ACC_CTL_BACKGROUND 1
`define ACC_CTL_FOREGROUND 2

// Status pin sources
`define ACC_PIN_SRC_FG 2'h0
`define ACC_PIN_SRC_STOPPED 2'h1
`define ACC_PIN_SRC_ALARM 2'h2

// Engine phase lengths in cycles at averaging code 0
`define ACC_FG_BASE_CYCLES 256
`define ACC_BG_BASE_CYCLES 128

`endif
